// *** sim/ccr_config_bank_chk.sv ***
// Purpose: Port-level assertions for the charger configuration bank.
// Assumes: One clock domain; srst synchronous and active high.
// Notes: Timing windows follow the pipeline latencies of this bank.
`timescale 1ns/10ps
module ccr_config_bank_chk
  import ccr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic sda_oe,
  input wire logic [15:0] external_current_limit_pin,
  input wire logic high_impedance_enable,
  input wire logic [15:0] input_voltage_floor,
  input wire logic [15:0] input_current_ceiling,
  input wire logic boost_output_enable,
  input wire logic charge_enable,
  input wire logic [15:0] minimum_system_voltage,
  input wire logic boost_current_high,
  input wire logic [5:0] fast_charge_current,
  input wire logic watchdog_restart,
  input wire logic register_reset
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Boost wins over charging at all times
  boost_over_charge_a: assert property (
    boost_output_enable |-> !charge_enable) else $error("charge on while boost on");
  floor_step_a: assert property (
    input_voltage_floor >= CCR_VIN_BASE_MV && input_voltage_floor <= 16'h13d8 &&
    (input_voltage_floor - CCR_VIN_BASE_MV) % CCR_VIN_STEP_MV == 16'h0000) else $error("floor off grid");
  sysmin_step_a: assert property (
    minimum_system_voltage >= CCR_SYS_BASE_MV && minimum_system_voltage <= 16'h0e74 &&
    (minimum_system_voltage - CCR_SYS_BASE_MV) % CCR_SYS_STEP_MV == 16'h0000) else $error("sysmin off grid");
  // Eight quiet cycles cover sync flops plus output register
  ceiling_limit_a: assert property (
    $stable(external_current_limit_pin) [*8] |-> input_current_ceiling <= external_current_limit_pin)
    else $error("ceiling above pin limit");
  reset_pulse_a: assert property (
    register_reset |=> !register_reset) else $error("register reset pulse too long");
  wdg_pulse_a: assert property (
    watchdog_restart |=> !watchdog_restart) else $error("watchdog pulse too long");
  reset_default_a: assert property (
    register_reset |-> ##[1:2] (charge_enable && boost_current_high && !boost_output_enable &&
    !high_impedance_enable && minimum_system_voltage == 16'h0dac &&
    input_voltage_floor == 16'h1108 && fast_charge_current == 6'h18)) else $error("defaults not restored");
  reset_quiet_a: assert property (
    $fell(srst) |-> !sda_oe && !register_reset && !watchdog_restart) else $error("outputs busy after reset");
  cover property (register_reset);
  cover property (watchdog_restart);
  cover property (boost_output_enable);
  cover property ($rose(sda_oe));
endmodule // ccr_config_bank_chk

bind ccr_config_bank ccr_config_bank_chk chk_u (.ref_clk, .srst, .sda_oe, .external_current_limit_pin,
  .high_impedance_enable, .input_voltage_floor, .input_current_ceiling, .boost_output_enable, .charge_enable,
  .minimum_system_voltage, .boost_current_high, .fast_charge_current, .watchdog_restart, .register_reset);

// *** sim/ccr_config_bank_test.sv ***
// Purpose: Self-checking bench for the charger configuration bank.
// Assumes: Host model drives the serial port; straps driven here.
// Notes: Random register values from a fixed seed plus corner cases.
`timescale 1ns/10ps
module ccr_config_bank_test;
  import ccr_pkg::*;
  logic ref_clk = 1'b0, srst, scl, sda_low, sda_wire, source_select_pin, boost_request_pin;
  logic sda_out, sda_oe, high_impedance_enable, boost_output_enable, charge_enable, boost_current_high;
  logic boost_cold_select, reduced_current_force, watchdog_restart, register_reset, a;
  logic [15:0] external_current_limit_pin, input_voltage_floor, input_current_ceiling, minimum_system_voltage;
  logic [5:0] fast_charge_current;
  logic [7:0] d;
  logic [31:0] v, x;
  int n_fail = 0, n_tests = 0, n_rst = 0, n_wdg = 0, seed = 23, acks, c0;
  always #4 ref_clk = !ref_clk;
  // Pull-up wire: low when either party pulls
  assign sda_wire = !(sda_low || sda_oe);
  always @(posedge ref_clk) begin
    if (register_reset === 1'b1) n_rst++;
    if (watchdog_restart === 1'b1) n_wdg++;
  end
  ccr_host_model host_u (.ref_clk(ref_clk), .sda_in(sda_wire), .scl_out(scl), .sda_low(sda_low));
  ccr_config_bank dut_u (.ref_clk(ref_clk), .srst(srst), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
    .sda_oe(sda_oe), .source_select_pin(source_select_pin), .boost_request_pin(boost_request_pin),
    .external_current_limit_pin(external_current_limit_pin), .high_impedance_enable(high_impedance_enable),
    .input_voltage_floor(input_voltage_floor), .input_current_ceiling(input_current_ceiling),
    .boost_output_enable(boost_output_enable), .charge_enable(charge_enable),
    .minimum_system_voltage(minimum_system_voltage), .boost_current_high(boost_current_high),
    .fast_charge_current(fast_charge_current), .boost_cold_select(boost_cold_select),
    .reduced_current_force(reduced_current_force), .watchdog_restart(watchdog_restart),
    .register_reset(register_reset));
  // ----------------------------------------------------------------
  // Expectation helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] ceil_ma(input logic [2:0] c, input logic [15:0] lim);
    logic [15:0] m;
    case (c)
      3'h0: m = CCR_ICL_CODE0_MA;
      3'h1: m = CCR_ICL_CODE1_MA;
      3'h2: m = CCR_ICL_CODE2_MA;
      3'h3: m = 16'h03e8;
      3'h4: m = 16'h05dc;
      3'h5: m = 16'h07d0;
      3'h6: m = 16'h09c4;
      default: m = CCR_ICL_CODE7_MA;
    endcase
    return (m < lim) ? m : lim;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge ref_clk);
    n_fail++;
    final_report();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    srst = 1'b1;
    source_select_pin = 1'b1;
    boost_request_pin = 1'b0;
    external_current_limit_pin = 16'h0bb8;
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
    repeat (12) @(negedge ref_clk);
    chk(input_voltage_floor, 16'h1108);
    chk(minimum_system_voltage, 16'h0dac);
    chk(charge_enable, 16'h0001);
    chk(boost_current_high, 16'h0001);
    chk(input_current_ceiling, CCR_ICL_CODE0_MA);
    chk(sda_out, 16'h0000);
    host_u.rd_reg(8'h00, d);
    chk(d, 16'h0030);
    host_u.rd_reg(8'h01, d);
    chk(d, 16'h001b);
    host_u.rd_reg(8'h02, d);
    chk(d, 16'h0060);
    // Random settings; first an all-ones input source with boost and charge both set, then an all-zeros corner
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      x = $random(seed);
      if (i == 0) begin
        v[7:0] = 8'hff;
        x[5:4] = 2'h3;
      end
      if (i == 1) begin
        v[7:0] = 8'h00;
        x[5:0] = 6'h00;
      end
      external_current_limit_pin = 16'h0064 + 16'(v[27:16] % 12'hbb8);
      host_u.wr_reg(8'h00, v[7:0], acks);
      chk(16'(acks), 16'h0003);
      host_u.wr_reg(8'h02, x[15:8], acks);
      host_u.wr_reg(8'h01, {2'h0, x[5:0]}, acks);
      repeat (2) @(negedge ref_clk);
      chk(high_impedance_enable, v[7]);
      chk(input_voltage_floor, CCR_VIN_BASE_MV + CCR_VIN_STEP_MV * v[6:3]);
      chk(input_current_ceiling, ceil_ma(v[2:0], external_current_limit_pin));
      chk(boost_output_enable, x[5]);
      chk(charge_enable, x[4] & !x[5]);
      chk(minimum_system_voltage, CCR_SYS_BASE_MV + CCR_SYS_STEP_MV * x[3:1]);
      chk(boost_current_high, x[0]);
      chk({fast_charge_current, boost_cold_select, reduced_current_force}, x[15:8]);
      host_u.rd_reg(8'h02, d);
      chk(d, x[15:8]);
    end
    // Multi-write running past the last register, then bad pointer and bad address
    host_u.start();
    host_u.byte_out({CCR_SLAVE_ADDR, 1'b0}, a);
    host_u.byte_out(8'h01, a);
    host_u.byte_out(8'h1a, a);
    chk(a, 16'h0001);
    host_u.byte_out(8'h55, a);
    chk(a, 16'h0001);
    host_u.byte_out(8'h77, a);
    chk(a, 16'h0000);
    host_u.stop();
    host_u.start();
    host_u.byte_out({CCR_SLAVE_ADDR, 1'b0}, a);
    host_u.byte_out(CCR_OFS_LIMIT, a);
    chk(a, 16'h0000);
    host_u.stop();
    host_u.start();
    host_u.byte_out({7'h6a, 1'b0}, a);
    chk(a, 16'h0000);
    host_u.stop();
    host_u.rd_reg(8'h01, d);
    chk(d, 16'h001a);
    host_u.rd_reg(8'h02, d);
    chk(d, 16'h0055);
    // Two watchdog restarts, spaced by the host model
    c0 = n_wdg;
    host_u.wr_reg(8'h01, 8'h5a, acks);
    host_u.wr_reg(8'h01, 8'h5a, acks);
    chk(16'(n_wdg - c0), 16'h0002);
    host_u.rd_reg(8'h01, d);
    chk(d, 16'h001a);
    // Register reset under each strap setting
    for (int s = 0; s < 3; s++) begin
      source_select_pin = (s != 0);
      boost_request_pin = (s == 2);
      host_u.wr_reg(8'h02, 8'h03, acks);
      c0 = n_rst;
      host_u.wr_reg(8'h01, 8'hbf, acks);
      chk(16'(n_rst - c0), 16'h0001);
      host_u.rd_reg(8'h00, d);
      chk(d, 16'h0030 | 16'((s == 0) ? 7 : 2 * (s - 1)));
      host_u.rd_reg(8'h01, d);
      chk(d, 16'h001b);
      host_u.rd_reg(8'h02, d);
      chk(d, 16'h0060);
      chk(input_current_ceiling, ceil_ma((s == 0) ? 3'h7 : 3'(2 * (s - 1)), external_current_limit_pin));
    end
    final_report();
  end
endmodule // ccr_config_bank_test

// *** sim/ccr_host_model.sv ***
// Purpose: Two-wire serial master standing in for the host processor.
// Assumes: Open-drain SDA resolved by the bench; SCL phases of 10 cycles.
// Notes: Signals move on the falling edge of ref_clk only.
`timescale 1ns/10ps
module ccr_host_model
  import ccr_pkg::*;
#(
  parameter int WDG_GAP = 2500
) (
  input wire logic ref_clk,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low
);
  int cyc = 0;
  int last_wdg = -100000;
  initial begin
    scl_out = 1'b1;
    sda_low = 1'b0;
  end
  always @(posedge ref_clk) cyc <= cyc + 1;
  // ----------------------------------------------------------------
  // Bit level; data moves 3 cycles after SCL falls for hold margin
  // ----------------------------------------------------------------
  task automatic w(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic start();
    w(3);
    sda_low = 1'b0;
    w(7);
    scl_out = 1'b1;
    w(10);
    sda_low = 1'b1;
    w(10);
    scl_out = 1'b0;
  endtask
  task automatic stop();
    w(3);
    sda_low = 1'b1;
    w(7);
    scl_out = 1'b1;
    w(10);
    sda_low = 1'b0;
    w(10);
  endtask
  task automatic bit_out(input logic b);
    w(3);
    sda_low = !b;
    w(7);
    scl_out = 1'b1;
    w(10);
    scl_out = 1'b0;
  endtask
  task automatic bit_in(output logic b);
    w(3);
    sda_low = 1'b0;
    w(7);
    scl_out = 1'b1;
    w(5);
    b = sda_in;
    w(5);
    scl_out = 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Byte level, MSB first
  // ----------------------------------------------------------------
  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic n;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(n);
    ack = !n;
  endtask
  task automatic byte_in(input logic mack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(!mack);
  endtask
  task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] d, output int acks);
    logic a;
    // Host spaces watchdog restarts by at least 20 us
    if (ptr == CCR_OFS_POWER_ON && d[CCR_WDG_BIT]) begin
      while (cyc - last_wdg < WDG_GAP) w(1);
      last_wdg = cyc;
    end
    acks = 0;
    start();
    byte_out({CCR_SLAVE_ADDR, 1'b0}, a);
    acks += a;
    byte_out(ptr, a);
    acks += a;
    byte_out(d, a);
    acks += a;
    stop();
  endtask
  // Single read: pointer write, repeated start, one byte, master NACK
  task automatic rd_reg(input logic [7:0] ptr, output logic [7:0] d);
    logic a;
    start();
    byte_out({CCR_SLAVE_ADDR, 1'b0}, a);
    byte_out(ptr, a);
    start();
    byte_out({CCR_SLAVE_ADDR, 1'b1}, a);
    byte_in(1'b0, d);
    stop();
  endtask
endmodule // ccr_host_model

// *** verilog/ccr_config_bank.sv ***
// Purpose: Charger configuration registers behind a two-wire serial slave.
// Assumes: Serial bit rate far below ref_clk; no clock stretching is needed.
// Notes: Watchdog timer and power stage sit outside and use the strobes.
`timescale 1ns/10ps
module ccr_config_bank
  import ccr_pkg::*;
#(
  parameter logic [15:0] ICL_CODE3_MA = 16'h03e8,
  parameter logic [15:0] ICL_CODE4_MA = 16'h05dc,
  parameter logic [15:0] ICL_CODE5_MA = 16'h07d0,
  parameter logic [15:0] ICL_CODE6_MA = 16'h09c4
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic source_select_pin,
  input wire logic boost_request_pin,
  input wire logic [15:0] external_current_limit_pin,
  output logic high_impedance_enable,
  output logic [15:0] input_voltage_floor,
  output logic [15:0] input_current_ceiling,
  output logic boost_output_enable,
  output logic charge_enable,
  output logic [15:0] minimum_system_voltage,
  output logic boost_current_high,
  output logic [5:0] fast_charge_current,
  output logic boost_cold_select,
  output logic reduced_current_force,
  output logic watchdog_restart,
  output logic register_reset
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] bus_level;
  logic [1:0] strap_level;
  logic [15:0] ext_limit_level;

  ccr_pin_sync #(.WIDTH(2), .INIT(2'h3)) u_bus_sync (
    .ref_clk(ref_clk), .srst(srst), .pin({scl_in, sda_in}), .level(bus_level));
  ccr_pin_sync #(.WIDTH(2), .INIT(2'h0)) u_strap_sync (
    .ref_clk(ref_clk), .srst(srst), .pin({source_select_pin, boost_request_pin}), .level(strap_level));
  ccr_pin_sync #(.WIDTH(16), .INIT(16'hffff)) u_limit_sync (
    .ref_clk(ref_clk), .srst(srst), .pin(external_current_limit_pin), .level(ext_limit_level));

  // ----------------------------------------------------------------
  // Bus events
  // ----------------------------------------------------------------
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= bus_level[1];
      sda_d_reg <= bus_level[0];
    end
  end

  assign scl_rise = bus_level[1] & ~scl_d_reg;
  assign scl_fall = ~bus_level[1] & scl_d_reg;
  assign bus_start = bus_level[1] & scl_d_reg & sda_d_reg & ~bus_level[0];
  assign bus_stop = bus_level[1] & scl_d_reg & ~sda_d_reg & bus_level[0];

  // ----------------------------------------------------------------
  // Registers and read mux
  // ----------------------------------------------------------------
  logic [7:0] input_source_reg;
  logic [5:0] power_on_reg;
  logic [7:0] charge_current_reg;
  logic [2:0] strap_cnt_reg;
  logic [2:0] strap_code;
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] ptr_reg;

  function automatic logic [7:0] read_mux(input logic [7:0] ofs, input logic [7:0] r0,
                                          input logic [5:0] r1, input logic [7:0] r2);
    case (ofs)
      CCR_OFS_INPUT_SOURCE: read_mux = r0;
      CCR_OFS_POWER_ON: read_mux = {2'b00, r1};
      CCR_OFS_CHARGE_CURRENT: read_mux = r2;
      default: read_mux = 8'h00;
    endcase
  endfunction

  // Strap decode from the settled source select and boost request levels
  assign strap_code = ~strap_level[1] ? CCR_ICL_STRAP_PSEL_LO :
                      (strap_level[0] ? CCR_ICL_STRAP_BOOST_HI : CCR_ICL_STRAP_BOOST_LO);

  // Register reset and watchdog restart strobes; self-clearing, so bit 7 never stores
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      register_reset <= 1'b0;
      watchdog_restart <= 1'b0;
    end else begin
      register_reset <= wr_en && ptr_reg == CCR_OFS_POWER_ON && wr_data[CCR_REGRST_BIT];
      watchdog_restart <= wr_en && ptr_reg == CCR_OFS_POWER_ON && wr_data[CCR_WDG_BIT];
    end
  end

  // Input source register; strap waits until the synchroniser has settled
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      input_source_reg <= {CCR_RST_INPUT_SOURCE_HI, 3'h0};
      strap_cnt_reg <= CCR_STRAP_SETTLE;
    end else begin
      if (strap_cnt_reg != 3'h0) begin
        strap_cnt_reg <= strap_cnt_reg - 3'h1;
      end
      if (register_reset) begin
        input_source_reg <= {CCR_RST_INPUT_SOURCE_HI, strap_code};
      end else if (wr_en && ptr_reg == CCR_OFS_INPUT_SOURCE) begin
        input_source_reg <= wr_data;
      end else if (strap_cnt_reg == 3'h1) begin // Three stages plus filter have settled
        input_source_reg[CCR_ICL_LSB +: 3] <= strap_code;
      end
    end
  end

  // Power-on and charge current registers
  always_ff @(posedge ref_clk) begin
    if (srst || register_reset) begin
      power_on_reg <= CCR_RST_POWER_ON[5:0];
      charge_current_reg <= CCR_RST_CHARGE_CURRENT;
    end else if (wr_en && ptr_reg == CCR_OFS_POWER_ON && !wr_data[CCR_REGRST_BIT]) begin
      // A reset write stores nothing, so no stray boost enable shows before defaults land
      power_on_reg <= wr_data[5:0];
    end else if (wr_en && ptr_reg == CCR_OFS_CHARGE_CURRENT) begin
      charge_current_reg <= wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Field outputs
  // ----------------------------------------------------------------
  logic [15:0] icl_ma;

  always_comb begin
    case (input_source_reg[CCR_ICL_LSB +: 3])
      3'h0: icl_ma = CCR_ICL_CODE0_MA;
      3'h1: icl_ma = CCR_ICL_CODE1_MA;
      3'h2: icl_ma = CCR_ICL_CODE2_MA;
      3'h3: icl_ma = ICL_CODE3_MA;
      3'h4: icl_ma = ICL_CODE4_MA;
      3'h5: icl_ma = ICL_CODE5_MA;
      3'h6: icl_ma = ICL_CODE6_MA;
      default: icl_ma = CCR_ICL_CODE7_MA;
    endcase
  end

  // Registered decodes, one cycle behind the register contents
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      high_impedance_enable <= 1'b0;
      input_voltage_floor <= CCR_VIN_BASE_MV;
      input_current_ceiling <= CCR_ICL_CODE0_MA;
      boost_output_enable <= 1'b0;
      charge_enable <= 1'b0;
      minimum_system_voltage <= CCR_SYS_BASE_MV;
      boost_current_high <= 1'b0;
      fast_charge_current <= 6'h00;
      boost_cold_select <= 1'b0;
      reduced_current_force <= 1'b0;
    end else begin
      high_impedance_enable <= input_source_reg[CCR_HIZ_BIT];
      input_voltage_floor <= CCR_VIN_BASE_MV + {12'h000, input_source_reg[CCR_VIN_LSB +: 4]} * CCR_VIN_STEP_MV;
      input_current_ceiling <= (icl_ma < ext_limit_level) ? icl_ma : ext_limit_level;
      boost_output_enable <= power_on_reg[CCR_BOOST_BIT];
      charge_enable <= power_on_reg[CCR_CHG_BIT] & ~power_on_reg[CCR_BOOST_BIT];
      minimum_system_voltage <= CCR_SYS_BASE_MV + {13'h0000, power_on_reg[CCR_SYSMIN_LSB +: 3]} * CCR_SYS_STEP_MV;
      boost_current_high <= power_on_reg[CCR_BLIM_BIT];
      fast_charge_current <= charge_current_reg[CCR_FAST_CHARGE_CURRENT_LSB +: 6];
      boost_cold_select <= charge_current_reg[CCR_BCOLD_BIT];
      reduced_current_force <= charge_current_reg[CCR_FORCE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Serial slave state machine
  // ----------------------------------------------------------------
  ccr_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] next_ptr;
  logic [7:0] next_rd;
  logic byte_done;

  assign byte_done = bit_cnt_reg == 4'h8;
  assign wr_en = scl_fall && state_reg == CCR_ST_WR && byte_done && ptr_reg < CCR_OFS_LIMIT;
  assign wr_data = shift_reg;
  assign next_ptr = ptr_reg + 8'h01;
  assign next_rd = read_mux(next_ptr, input_source_reg, power_on_reg, charge_current_reg);
  assign sda_out = 1'b0; // Open drain: only ever pulls low

  // One transfer step per SCL edge; start and stop override any state
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= CCR_ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      sda_oe <= 1'b0;
    end else if (bus_start) begin
      state_reg <= CCR_ST_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe <= 1'b0;
    end else if (bus_stop) begin
      state_reg <= CCR_ST_IDLE;
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      if (state_reg == CCR_ST_ADDR || state_reg == CCR_ST_PTR || state_reg == CCR_ST_WR) begin
        shift_reg <= {shift_reg[6:0], bus_level[0]};
      end else if (state_reg == CCR_ST_RD_ACK && bus_level[0]) begin
        state_reg <= CCR_ST_IDLE; // Master NACK ends the read
      end
    end else if (scl_fall) begin
      case (state_reg)
        CCR_ST_ADDR: begin
          if (byte_done) begin
            state_reg <= (shift_reg[7:1] == CCR_SLAVE_ADDR) ? CCR_ST_ADDR_ACK : CCR_ST_IDLE;
            sda_oe <= shift_reg[7:1] == CCR_SLAVE_ADDR;
          end
        end
        CCR_ST_ADDR_ACK: begin
          bit_cnt_reg <= 4'h0;
          if (shift_reg[0]) begin
            state_reg <= CCR_ST_RD;
            shift_reg <= read_mux(ptr_reg, input_source_reg, power_on_reg, charge_current_reg);
            sda_oe <= ~read_mux(ptr_reg, input_source_reg, power_on_reg, charge_current_reg) >> 7 == 8'h01;
          end else begin
            state_reg <= CCR_ST_PTR;
            sda_oe <= 1'b0;
          end
        end
        CCR_ST_PTR: begin
          if (byte_done) begin
            state_reg <= (shift_reg < CCR_OFS_LIMIT) ? CCR_ST_PTR_ACK : CCR_ST_IDLE;
            sda_oe <= shift_reg < CCR_OFS_LIMIT;
            ptr_reg <= shift_reg;
          end
        end
        CCR_ST_WR: begin
          if (byte_done) begin
            state_reg <= (ptr_reg < CCR_OFS_LIMIT) ? CCR_ST_WR_ACK : CCR_ST_IDLE;
            sda_oe <= ptr_reg < CCR_OFS_LIMIT;
          end
        end
        CCR_ST_PTR_ACK, CCR_ST_WR_ACK: begin
          if (state_reg == CCR_ST_WR_ACK) begin
            ptr_reg <= next_ptr; // Auto-increment for multi-write
          end
          state_reg <= CCR_ST_WR;
          bit_cnt_reg <= 4'h0;
          sda_oe <= 1'b0;
        end
        CCR_ST_RD: begin
          if (byte_done) begin
            state_reg <= CCR_ST_RD_ACK;
            sda_oe <= 1'b0;
          end else begin
            sda_oe <= ~shift_reg[3'(4'h7 - bit_cnt_reg)];
          end
        end
        CCR_ST_RD_ACK: begin
          state_reg <= CCR_ST_RD;
          bit_cnt_reg <= 4'h0;
          ptr_reg <= next_ptr;
          shift_reg <= next_rd;
          sda_oe <= ~next_rd[7];
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

endmodule // ccr_config_bank

// *** verilog/ccr_pin_sync.sv ***
// Purpose: Three-stage synchroniser for pins from outside the clock domain.
// Assumes: Each bit is an independent level; multi-bit buses are quasi-static.
// Notes: A bit changes only once stages two and three agree.
`timescale 1ns/10ps
module ccr_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] agree;

  // Stage one feeds stage two only
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stage1_reg <= INIT;
      stage2_reg <= INIT;
      stage3_reg <= INIT;
    end else begin
      stage1_reg <= pin;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  assign agree = ~(stage2_reg ^ stage3_reg);

  // Filter: hold a bit while its last two stages disagree
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      level <= INIT;
    end else begin
      level <= (level & ~agree) | (stage3_reg & agree);
    end
  end

endmodule // ccr_pin_sync

// *** verilog/ccr_pkg.sv ***
// Purpose: Shared constants for the charger configuration register bank.
// Assumes: Byte-wide registers reached over a two-wire serial slave port.
// Notes: Millivolt and milliamp figures are 16-bit unsigned quantities.
package ccr_pkg;

  // ----------------------------------------------------------------
  // Register offsets and serial address
  // ----------------------------------------------------------------
  localparam logic [7:0] CCR_OFS_INPUT_SOURCE = 8'h00;
  localparam logic [7:0] CCR_OFS_POWER_ON = 8'h01;
  localparam logic [7:0] CCR_OFS_CHARGE_CURRENT = 8'h02;
  localparam logic [7:0] CCR_OFS_LIMIT = 8'h03;
  localparam logic [6:0] CCR_SLAVE_ADDR = 7'h6b;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CCR_HIZ_BIT = 7;
  localparam int CCR_VIN_LSB = 3;
  localparam int CCR_ICL_LSB = 0;
  localparam int CCR_REGRST_BIT = 7;
  localparam int CCR_WDG_BIT = 6;
  localparam int CCR_BOOST_BIT = 5;
  localparam int CCR_CHG_BIT = 4;
  localparam int CCR_SYSMIN_LSB = 1;
  localparam int CCR_BLIM_BIT = 0;
  localparam int CCR_FAST_CHARGE_CURRENT_LSB = 2;
  localparam int CCR_BCOLD_BIT = 1;
  localparam int CCR_FORCE_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] CCR_RST_INPUT_SOURCE_HI = 5'h06;
  localparam logic [7:0] CCR_RST_POWER_ON = 8'h1b;
  localparam logic [7:0] CCR_RST_CHARGE_CURRENT = 8'h60;
  localparam logic [2:0] CCR_ICL_STRAP_PSEL_LO = 3'h7;
  localparam logic [2:0] CCR_ICL_STRAP_BOOST_LO = 3'h0;
  localparam logic [2:0] CCR_ICL_STRAP_BOOST_HI = 3'h2;

  // ----------------------------------------------------------------
  // Scales and timing
  // ----------------------------------------------------------------
  localparam logic [15:0] CCR_VIN_BASE_MV = 16'h0f28;
  localparam logic [15:0] CCR_VIN_STEP_MV = 16'h0050;
  localparam logic [15:0] CCR_SYS_BASE_MV = 16'h0bb8;
  localparam logic [15:0] CCR_SYS_STEP_MV = 16'h0064;
  localparam logic [15:0] CCR_ICL_CODE0_MA = 16'h0064;
  localparam logic [15:0] CCR_ICL_CODE1_MA = 16'h0096;
  localparam logic [15:0] CCR_ICL_CODE2_MA = 16'h01f4;
  localparam logic [15:0] CCR_ICL_CODE7_MA = 16'h0bb8;
  localparam logic [2:0] CCR_STRAP_SETTLE = 3'h5;

  // Serial port states
  typedef enum logic [3:0] {
    CCR_ST_IDLE = 4'b0000,
    CCR_ST_ADDR = 4'b0001,
    CCR_ST_ADDR_ACK = 4'b0010,
    CCR_ST_PTR = 4'b0011,
    CCR_ST_PTR_ACK = 4'b0100,
    CCR_ST_WR = 4'b0101,
    CCR_ST_WR_ACK = 4'b0110,
    CCR_ST_RD = 4'b0111,
    CCR_ST_RD_ACK = 4'b1000
  } ccr_state_t;

endpackage
